/* verif/alr_host.sv */
`timescale 1ns/1ps
// Bus master model: open-drain data line, clock idles high between frames
module alr_host (
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hcyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   // Start and repeated start share one shape
   task automatic start();
      hcyc(2);
      sda_low = 1'b0;
      hcyc(2);
      scl = 1'b1;
      hcyc(2);
      sda_low = 1'b1;
      hcyc(2);
      scl = 1'b0;
   endtask
   task automatic stop();
      hcyc(2);
      sda_low = 1'b1;
      hcyc(2);
      scl = 1'b1;
      hcyc(2);
      sda_low = 1'b0;
      hcyc(4);
   endtask
   // One 800 ns bit; data moves mid low phase, sampled late in high phase
   task automatic hbit(input logic b, output logic r);
      hcyc(2);
      sda_low = ~b;
      hcyc(2);
      scl = 1'b1;
      hcyc(4);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         hbit(b[i], r);
      hbit(1'b1, r);
      ack = ~r;
   endtask
   // Master acks every byte but the last
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         hbit(1'b1, r);
         b[i] = r;
      end
      hbit(last, r);
   endtask
   task automatic wr(input logic [7:0] ptr, input logic [7:0] v, output logic ok);
      logic a0, a1, a2;
      start();
      wbyte(alr_pkg::WR_ADDR_BYTE, a0);
      wbyte(ptr, a1);
      wbyte(v, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   // Address-only write sets the pointer, then two bytes are read back
   task automatic rd16(input logic [7:0] ptr, input logic use_sr, output logic [15:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      wbyte(alr_pkg::WR_ADDR_BYTE, a0);
      wbyte(ptr, a1);
      if (!use_sr)
         stop();
      start();
      wbyte(alr_pkg::RD_ADDR_BYTE, a2);
      rbyte(1'b0, d[15:8]);
      rbyte(1'b1, d[7:0]);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule

/* verif/alr_top_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         miscompares++; \
         $display("[FAIL] %s expected %h seen %h", nm, e, g); \
      end \
   end
module alr_top_tb;
   // Short frame keeps the run brief; must exceed the longest run used here
   localparam int FRAME = 40000;
   logic sys_clk, resetn, scl, host_low, sda_out, sda_oe, adc_start, ir_sink_en, standby, ok;
   logic [15:0] adc_data, d;
   wire sda_line = (host_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   int miscompares = 0;
   int tests_run = 0;
   int cyc = 0;
   int pcount = 0;
   int ptime[64];
   alr_top #(.FRAME_CYCLES(FRAME)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .adc_data(adc_data), .adc_start(adc_start),
      .ir_sink_en(ir_sink_en), .standby(standby));
   alr_host i_host (.sys_clk(sys_clk), .sda(sda_line), .scl(scl), .sda_low(host_low));
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Sample value depends on its index, so a lost or doubled sample shows
   function automatic logic [15:0] smp(input int i);
      return 16'h1000 + 16'(i) * 16'h0234;
   endfunction
   // Start pulse log; data changes at each start, taken at measurement end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (adc_start === 1'b1)
      begin
         if (pcount < 64)
            ptime[pcount] = cyc;
         pcount++;
      end
   end
   always @(negedge sys_clk)
      adc_data = smp(pcount);
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic test_done();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_idle();
      int p0;
      p0 = pcount;
      `CHK("standby", 1'b1, standby);
      `CHK("ir_sink", 1'b0, ir_sink_en);
      wait_cyc(4000);
      `CHK("idle pulses", p0, pcount);
      i_host.start();
      i_host.wbyte(8'h4c, ok);
      i_host.stop();
      `CHK("foreign addr ack", 1'b0, ok);
      $display("test idle done");
   endtask
   task automatic t_framed();
      int p0;
      logic [16:0] s;
      i_host.wr(alr_pkg::REG_CFG, 8'h01, ok);
      `CHK("wr ack", 1'b1, ok);
      i_host.rd16(alr_pkg::REG_CFG, 1'b0, d, ok);
      `CHK("cfg readback", 8'h01, d[15:8]);
      `CHK("rd ack", 1'b1, ok);
      p0 = pcount;
      i_host.wr(alr_pkg::REG_CMD, 8'h01, ok);
      `CHK("standby off", 1'b0, standby);
      wait_cyc(10000);
      `CHK("pulses in frame", p0 + 2, pcount);
      `CHK("meas spacing", alr_pkg::MEAS_CYC, ptime[p0 + 1] - ptime[p0]);
      `CHK("ir_sink run", 1'b0, ir_sink_en);
      i_host.rd16(alr_pkg::REG_RES_HI, 1'b1, d, ok);
      `CHK("early result", 16'h0000, d);
      wait_cyc(ptime[p0] + FRAME + 200 - cyc);
      s = 17'(smp(p0 + 1)) + 17'(smp(p0 + 2));
      i_host.rd16(alr_pkg::REG_RES_HI, 1'b1, d, ok);
      `CHK("framed result", s[16:1], d);
      $display("test framed done");
   endtask
   task automatic t_cont();
      int p0;
      logic [17:0] s;
      i_host.wr(alr_pkg::REG_CMD, 8'h00, ok);
      wait_cyc(10);
      `CHK("standby back", 1'b1, standby);
      i_host.wr(alr_pkg::REG_CFG, 8'h82, ok);
      p0 = pcount;
      i_host.wr(alr_pkg::REG_CMD, 8'h01, ok);
      for (int i = 0; i < 20000 && pcount < p0 + 4; i++)
         wait_cyc(1);
      for (int k = 1; k < 4; k++)
         `CHK("back to back", alr_pkg::MEAS_CYC, ptime[p0 + k] - ptime[p0 + k - 1]);
      wait_cyc(alr_pkg::MEAS_CYC + 50);
      s = 18'(smp(p0 + 1)) + 18'(smp(p0 + 2)) + 18'(smp(p0 + 3)) + 18'(smp(p0 + 4));
      i_host.rd16(alr_pkg::REG_RES_HI, 1'b1, d, ok);
      `CHK("cont result", s[17:2], d);
      $display("test continuous done");
   endtask
   // Reset, then scenarios in order
   initial
   begin
      resetn = 1'b0;
      repeat (8) @(negedge sys_clk);
      resetn = 1'b1;
      wait_cyc(10);
      t_idle();
      t_framed();
      t_cont();
      test_done();
   end
   // Whole sequence needs about 59000 cycles
   initial
   begin
      repeat (100000) @(posedge sys_clk);
      miscompares++;
      $display("[FAIL] watchdog expired");
      test_done();
   end
endmodule

/* verilog/alr_meas_if.sv */
`timescale 1ns/1ps
interface alr_meas_if;
   logic en;
   logic cont;
   logic [alr_pkg::AVG_W-1:0] avg;
   logic [15:0] result;
   logic valid;
   modport ctl (output en, output cont, output avg, input result, input valid);
   modport seq (input en, input cont, input avg, output result, output valid);
endinterface

/* verilog/alr_pkg.sv */
package alr_pkg;
   // Bus address bytes, write and read form
   localparam logic [7:0] WR_ADDR_BYTE = 8'h26;
   localparam logic [7:0] RD_ADDR_BYTE = 8'h27;
   // Register offsets
   localparam logic [7:0] REG_CMD = 8'h80;
   localparam logic [7:0] REG_CFG = 8'h84;
   localparam logic [7:0] REG_RES_HI = 8'h85;
   localparam logic [7:0] REG_RES_LO = 8'h86;
   // Field positions
   localparam int CMD_ALS_EN_BIT = 0;
   localparam int CFG_CONT_BIT = 7;
   localparam int CFG_AVG_LSB = 0;
   localparam int AVG_W = 3;
   // Reset values
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int MEAS_US = 300;
   localparam int MEAS_CYC = (CLK_HZ / 1_000_000) * MEAS_US;
   localparam int FRAME_MS = 100;
   localparam int FRAME_CYC = (CLK_HZ / 1000) * FRAME_MS;
endpackage

/* verilog/alr_seq.sv */
`timescale 1ns/1ps
module alr_seq #(
   parameter int FRAME_CYCLES = alr_pkg::FRAME_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   alr_meas_if.seq m,
   input wire logic [15:0] adc_data,
   output logic adc_start
);
   typedef enum logic [1:0] {S_IDLE, S_MEAS, S_WAIT} alr_seq_e;
   alr_seq_e st_r;
   logic [11:0] mc_r;
   logic [31:0] fc_r;
   logic [7:0] cnt_r;
   logic [22:0] acc_r;
   logic cont_r;
   logic [alr_pkg::AVG_W-1:0] avg_r;
   logic [15:0] result_r;
   logic valid_r;
   logic meas_done;
   logic last;
   logic frame_end;
   logic publish;
   logic [7:0] target;
   logic [22:0] acc_sum;

   // Measurement progress decode
   assign meas_done = (st_r == S_MEAS) && (mc_r == 12'(alr_pkg::MEAS_CYC - 1));
   assign target = 8'h01 << avg_r;
   assign last = (cnt_r == 8'(target - 8'h01));
   assign acc_sum = acc_r + {7'h00, adc_data};
   assign frame_end = (fc_r >= 32'(FRAME_CYCLES - 1));
   // Continuous mode publishes on the last sample, framed mode waits for the frame
   assign publish = (meas_done && last && cont_r) || (st_r == S_WAIT && frame_end);
   assign adc_start = (st_r == S_MEAS) && (mc_r == 12'h000);
   assign m.result = result_r;
   assign m.valid = valid_r;

   // Sequencer state; dropping the enable idles everything at once
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= S_IDLE;
      else if (!m.en)
         st_r <= S_IDLE;
      else
         unique case (st_r)
            S_IDLE: st_r <= S_MEAS;
            S_MEAS:
            begin
               if (meas_done && last && !cont_r)
                  st_r <= S_WAIT;
            end
            S_WAIT:
            begin
               if (frame_end)
                  st_r <= S_MEAS;
            end
         endcase
   end

   // Per-measurement and per-frame counters
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mc_r <= 12'h000;
         fc_r <= 32'h0000_0000;
      end
      else
      begin
         if (st_r != S_MEAS || meas_done)
            mc_r <= 12'h000;
         else
            mc_r <= mc_r + 12'h001;
         if (st_r == S_IDLE || publish)
            fc_r <= 32'h0000_0000;
         else
            fc_r <= fc_r + 32'h0000_0001;
      end
   end

   // Accumulator; mode and count are frozen for a whole averaging run
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_r <= 23'h000000;
         cnt_r <= 8'h00;
         cont_r <= 1'b0;
         avg_r <= '0;
      end
      else if (st_r == S_IDLE || publish)
      begin
         acc_r <= 23'h000000;
         cnt_r <= 8'h00;
         cont_r <= m.cont;
         avg_r <= m.avg;
      end
      else if (meas_done)
      begin
         acc_r <= acc_sum;
         cnt_r <= cnt_r + 8'h01;
      end
   end

   // Result register; shift divides since counts are powers of two
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         result_r <= 16'h0000;
         valid_r <= 1'b0;
      end
      else
      begin
         valid_r <= publish && m.en;
         if (publish && m.en)
            result_r <= 16'((cont_r ? acc_sum : acc_r) >> avg_r);
      end
   end

   a_meas_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      adc_start |=> (!adc_start) [*8]) else $error("measurement shorter than expected");
   a_frame_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (valid_r && !$past(cont_r)) |-> ($past(fc_r) >= 32'(FRAME_CYCLES - 1)))
      else $error("framed result before frame end");
   a_back_to_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (meas_done && cont_r && m.en) ##1 m.en |-> adc_start)
      else $error("gap between continuous measurements");
   a_cont_publish: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (meas_done && last && cont_r && m.en) |=> valid_r)
      else $error("continuous result not published");
endmodule

/* verilog/alr_top.sv */
`timescale 1ns/1ps
module alr_top #(
   parameter int FRAME_CYCLES = alr_pkg::FRAME_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [15:0] adc_data,
   output logic adc_start,
   output logic ir_sink_en,
   output logic standby
);
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_PTR, I_WDAT, I_WACK, I_RDAT, I_RACK} alr_i2c_e;
   alr_i2c_e st_r;
   logic rs_m_r;
   logic rst_n;
   logic scl_m_r;
   logic scl_s_r;
   logic scl_d_r;
   logic sda_m_r;
   logic sda_s_r;
   logic sda_d_r;
   logic [7:0] sh_r;
   logic [2:0] bitc_r;
   logic got8_r;
   logic rw_r;
   logic nack_r;
   logic oe_r;
   logic [7:0] ptr_r;
   logic [7:0] cmd_r;
   logic [7:0] cfg_r;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic wr_stb;
   logic [7:0] rd_now;
   alr_meas_if mif ();

   // Read mux over the register map; unmapped addresses read zero
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] cmd,
                                         input logic [7:0] cfg, input logic [15:0] res);
      unique case (a)
         alr_pkg::REG_CMD: rd_byte = cmd;
         alr_pkg::REG_CFG: rd_byte = cfg;
         alr_pkg::REG_RES_HI: rd_byte = res[15:8];
         alr_pkg::REG_RES_LO: rd_byte = res[7:0];
         default: rd_byte = 8'h00;
      endcase
   endfunction

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rs_m_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rs_m_r <= 1'b1;
         rst_n <= rs_m_r;
      end
   end

   // Pin synchronisers; the third stage only feeds edge detection
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_m_r <= scl;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= sda_in;
         sda_s_r <= sda_m_r;
         sda_d_r <= sda_s_r;
      end
   end

   // Bus condition decode
   assign scl_rise = scl_s_r && !scl_d_r;
   assign scl_fall = !scl_s_r && scl_d_r;
   assign start_c = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
   assign stop_c = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
   assign rd_now = rd_byte(ptr_r, cmd_r, cfg_r, mif.result);
   assign wr_stb = scl_fall && got8_r && (st_r == I_WDAT) && !start_c && !stop_c;

   // Open-drain data pin: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = oe_r;
   // Emitter belongs to proximity, never run from here, so standby keeps it off
   assign ir_sink_en = 1'b0;
   assign standby = !cmd_r[alr_pkg::CMD_ALS_EN_BIT];

   // Serial slave; a start in any state restarts address reception
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= I_IDLE;
         sh_r <= 8'h00;
         bitc_r <= 3'h0;
         got8_r <= 1'b0;
         rw_r <= 1'b0;
         nack_r <= 1'b0;
         oe_r <= 1'b0;
         ptr_r <= 8'h00;
      end
      else if (start_c)
      begin
         st_r <= I_ADDR;
         bitc_r <= 3'h0;
         got8_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else if (stop_c)
      begin
         st_r <= I_IDLE;
         oe_r <= 1'b0;
      end
      else if (scl_rise)
      begin
         unique case (st_r)
            I_ADDR, I_PTR, I_WDAT:
            begin
               sh_r <= {sh_r[6:0], sda_s_r};
               bitc_r <= bitc_r + 3'h1;
               got8_r <= (bitc_r == 3'h7);
            end
            I_RDAT:
            begin
               sh_r <= {sh_r[6:0], 1'b0};
               bitc_r <= bitc_r + 3'h1;
               got8_r <= (bitc_r == 3'h7);
            end
            I_RACK: nack_r <= sda_s_r;
            I_IDLE, I_AACK, I_WACK: ;
         endcase
      end
      else if (scl_fall)
      begin
         unique case (st_r)
            I_ADDR:
            begin
               if (got8_r)
               begin
                  got8_r <= 1'b0;
                  if (sh_r == alr_pkg::WR_ADDR_BYTE || sh_r == alr_pkg::RD_ADDR_BYTE)
                  begin
                     oe_r <= 1'b1;
                     rw_r <= (sh_r == alr_pkg::RD_ADDR_BYTE);
                     st_r <= I_AACK;
                  end
                  else
                     st_r <= I_IDLE;
               end
            end
            I_AACK:
            begin
               if (rw_r)
               begin
                  sh_r <= rd_now;
                  oe_r <= !rd_now[7];
                  st_r <= I_RDAT;
               end
               else
               begin
                  oe_r <= 1'b0;
                  st_r <= I_PTR;
               end
            end
            I_PTR:
            begin
               if (got8_r)
               begin
                  ptr_r <= sh_r;
                  got8_r <= 1'b0;
                  oe_r <= 1'b1;
                  st_r <= I_WACK;
               end
            end
            I_WDAT:
            begin
               if (got8_r)
               begin
                  ptr_r <= ptr_r + 8'h01;
                  got8_r <= 1'b0;
                  oe_r <= 1'b1;
                  st_r <= I_WACK;
               end
            end
            I_WACK:
            begin
               oe_r <= 1'b0;
               st_r <= I_WDAT;
            end
            I_RDAT:
            begin
               if (got8_r)
               begin
                  got8_r <= 1'b0;
                  oe_r <= 1'b0;
                  ptr_r <= ptr_r + 8'h01;
                  st_r <= I_RACK;
               end
               else
                  oe_r <= !sh_r[7];
            end
            I_RACK:
            begin
               // Master nack ends the read; the pointer already moved on
               if (nack_r)
               begin
                  oe_r <= 1'b0;
                  st_r <= I_IDLE;
               end
               else
               begin
                  sh_r <= rd_now;
                  oe_r <= !rd_now[7];
                  st_r <= I_RDAT;
               end
            end
            I_IDLE: ;
         endcase
      end
   end

   // Writable registers; result is read-only
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_r <= alr_pkg::CMD_RST;
         cfg_r <= alr_pkg::CFG_RST;
      end
      else if (wr_stb)
      begin
         if (ptr_r == alr_pkg::REG_CMD)
            cmd_r <= sh_r;
         if (ptr_r == alr_pkg::REG_CFG)
            cfg_r <= sh_r;
      end
   end

   // Controls for the sequencer
   assign mif.en = cmd_r[alr_pkg::CMD_ALS_EN_BIT];
   assign mif.cont = cfg_r[alr_pkg::CFG_CONT_BIT];
   assign mif.avg = cfg_r[alr_pkg::CFG_AVG_LSB +: alr_pkg::AVG_W];

   alr_seq #(
      .FRAME_CYCLES(FRAME_CYCLES)
   ) u_seq (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .m(mif.seq),
      .adc_data(adc_data),
      .adc_start(adc_start)
   );

   a_standby_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (standby && $past(standby)) |-> !adc_start) else $error("conversion in standby");
   a_sink_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      standby |-> !ir_sink_en) else $error("emitter sink on in standby");
   a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(st_r) == I_AACK && st_r == I_RDAT) |-> sh_r == $past(rd_now))
      else $error("read byte not from pointer");
   a_restart_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start_c |=> st_r == I_ADDR) else $error("start not accepted");
   a_ptr_incr: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(st_r) == I_RDAT && st_r == I_RACK) |-> ptr_r == 8'($past(ptr_r) + 8'h01))
      else $error("pointer not incremented after read");
   a_addr_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (st_r == I_AACK && $past(st_r) == I_ADDR) |->
      ($past(sh_r) == alr_pkg::WR_ADDR_BYTE || $past(sh_r) == alr_pkg::RD_ADDR_BYTE))
      else $error("acked foreign address");
endmodule
